//--- shared/pmu_regs_pkg.sv
// Package with register offsets, field positions and reset values.
package pmu_regs_pkg;
    // Register offsets on the byte-wide register port.
    localparam logic [7:0] FAULT_FLAGS_ADDR   = 8'h01;
    localparam logic [7:0] ENABLE_DIM_ADDR    = 8'h02;
    localparam logic [7:0] MODE_LDO_ADDR      = 8'h03;
    // Reset values of the three registers.
    localparam logic [7:0] FAULT_FLAGS_RESET  = 8'h00;
    localparam logic [7:0] ENABLE_DIM_RESET   = 8'h00;
    localparam logic [7:0] MODE_LDO_RESET     = 8'hfc;
    // Field positions inside the enable register.
    localparam int BUCK_C_EN_BIT    = 7;
    localparam int LOW_LDO_EN_BIT   = 6;
    localparam int SECOND_LDO_EN_BIT = 5;
    localparam int DIM_MSB          = 4;
    // Field positions inside the mode register.
    localparam int MODE_MSB         = 7;
    localparam int MODE_LSB         = 4;
    localparam int LDO_CODE_MSB     = 3;
    // Dimming field value that switches the backlight off.
    localparam logic [4:0] DIM_OFF  = 5'h00;
    // Full-scale dimming code; reference = code / 31 * 0.25 V.
    localparam logic [4:0] DIM_FULL = 5'h1f;
    // Bus read answer for an unmapped offset.
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : pmu_regs_pkg

//--- logic/pmu_channel_control_regs.sv
// Byte-wide fault, enable and mode registers of the power unit.
`timescale 1ns/1ps
module pmu_channel_control_regs (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic [7:0] faultEvent,
    output logic            buckCEnable,
    output logic            lowInputLdoEnable,
    output logic            secondLdoEnable,
    output logic            backlightEnable,
    output logic      [4:0] backlightFeedbackReference,
    output logic      [3:0] switchingModeSelect,
    output logic      [3:0] ldoOutputCode
);
    import pmu_regs_pkg::*;

    // Fault event lines come from analog comparators, so synchronise them.
    logic [7:0] faultSyncA_reg;    // First stage, read only by second stage.
    logic [7:0] faultSyncB_reg;    // Second stage, safe to use.
    // Register state and its next values.
    logic [7:0] faultFlags_reg;
    logic [7:0] faultFlags_next;
    logic [7:0] enableDim_reg;
    logic [7:0] enableDim_next;
    logic [7:0] modeLdo_reg;
    logic [7:0] modeLdo_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    // Returns true when the bus hits the given offset with a write.
    function automatic logic wrHit(input logic [7:0] addr,
                                   input logic       wr,
                                   input logic [7:0] target);
        wrHit = wr && (addr == target);
    endfunction : wrHit

    // Synchroniser for the asynchronous fault events.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            faultSyncA_reg <= 8'h00;
            faultSyncB_reg <= 8'h00;
        end else begin
            faultSyncA_reg <= faultEvent;
            faultSyncB_reg <= faultSyncA_reg;
        end
    end

    // Next register values. A fault in the same cycle as a host write
    // of zero keeps the flag set, so no event is ever lost.
    always_comb begin
        faultFlags_next = faultFlags_reg;
        enableDim_next  = enableDim_reg;
        modeLdo_next    = modeLdo_reg;
        if (wrHit(regAddr, regWrite, FAULT_FLAGS_ADDR)) begin
            faultFlags_next = regWrData;
        end
        faultFlags_next = faultFlags_next | faultSyncB_reg;
        if (wrHit(regAddr, regWrite, ENABLE_DIM_ADDR)) begin
            enableDim_next = regWrData;
        end
        if (wrHit(regAddr, regWrite, MODE_LDO_ADDR)) begin
            modeLdo_next = regWrData;
        end
    end

    // Read data mux; unmapped offsets answer zero.
    always_comb begin
        rdData_next = rdData_reg;
        if (regRead) begin
            case (regAddr)
                FAULT_FLAGS_ADDR: begin
                    rdData_next = faultFlags_reg;
                end
                ENABLE_DIM_ADDR: begin
                    rdData_next = enableDim_reg;
                end
                MODE_LDO_ADDR: begin
                    rdData_next = modeLdo_reg;
                end
                default: begin
                    rdData_next = UNMAPPED_READ;
                end
            endcase
        end
    end

    // Register bank and read data flops.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            faultFlags_reg <= FAULT_FLAGS_RESET;
            enableDim_reg  <= ENABLE_DIM_RESET;
            modeLdo_reg    <= MODE_LDO_RESET;
            rdData_reg     <= 8'h00;
        end else begin
            faultFlags_reg <= faultFlags_next;
            enableDim_reg  <= enableDim_next;
            modeLdo_reg    <= modeLdo_next;
            rdData_reg     <= rdData_next;
        end
    end

    // Outputs straight from flip-flops. Backlight enable is a decode of
    // the dimming field, so it is kept as its own flop to stay glitch free;
    // one extra register is traded for a clean enable on the analog side.
    logic backlightEn_reg;     // Registered backlight channel enable.
    logic backlightEn_next;    // Decode of the next dimming field value.

    // Decode of the next dimming field: zero is off, anything else on.
    always_comb begin
        backlightEn_next = 1'b0;
        if (enableDim_next[DIM_MSB:0] != DIM_OFF) begin
            backlightEn_next = 1'b1;
        end
    end

    // Register the enable on the same edge as the dimming field itself.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            backlightEn_reg <= 1'b0;
        end else begin
            backlightEn_reg <= backlightEn_next;
        end
    end

    assign regRdData                  = rdData_reg;
    assign buckCEnable                = enableDim_reg[BUCK_C_EN_BIT];
    assign lowInputLdoEnable          = enableDim_reg[LOW_LDO_EN_BIT];
    assign secondLdoEnable            = enableDim_reg[SECOND_LDO_EN_BIT];
    assign backlightEnable            = backlightEn_reg;
    // The analog side scales this code by 0.25 V / 31
    assign backlightFeedbackReference = enableDim_reg[DIM_MSB:0];
    assign switchingModeSelect        = modeLdo_reg[MODE_MSB:MODE_LSB];
    assign ldoOutputCode              = modeLdo_reg[LDO_CODE_MSB:0];

    // Every check below runs on the register clock and is silent while
    // reset is held, so no check sees the reset transient.
    default clocking regClk @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // A set flag may only drop when the host writes the flag register.
    a_fault_sticky: assert property (
        (faultFlags_reg != 8'h00)
        && !wrHit(regAddr, regWrite, FAULT_FLAGS_ADDR)
        |=> ((faultFlags_reg & $past(faultFlags_reg))
             == $past(faultFlags_reg)))
        else $error("Fault flag dropped without a write.");
    // Two synchroniser stages and the flag flop: set three edges later.
    a_fault_capture: assert property (
        faultEvent[0] |-> ##3 faultFlags_reg[0])
        else $error("Fault event not captured.");
    // The most significant flag belongs to the top channel.
    a_fault_top: assert property (
        faultEvent[7] |-> ##3 faultFlags_reg[7])
        else $error("Top channel fault not captured.");
    // A write with no event pending lands exactly as written.
    a_fault_write: assert property (
        wrHit(regAddr, regWrite, FAULT_FLAGS_ADDR) && faultSyncB_reg == 8'h00
        |=> faultFlags_reg == $past(regWrData))
        else $error("Fault register write lost.");
    // A flag read returns the value held before any same-cycle write.
    a_read_fault: assert property (
        regRead && regAddr == FAULT_FLAGS_ADDR
        |=> regRdData == $past(faultFlags_reg))
        else $error("Fault register read wrong.");
    // A zero dimming field keeps the backlight channel off.
    a_dim_off: assert property (
        (enableDim_reg[DIM_MSB:0] == DIM_OFF) |-> !backlightEnable)
        else $error("Backlight on with zero dimming.");
    // Any nonzero dimming code turns the backlight channel on.
    a_dim_on: assert property (
        (backlightFeedbackReference != DIM_OFF) |-> backlightEnable)
        else $error("Backlight off with nonzero dimming.");
    // The reference code follows a write of the dimming field.
    a_dim_ref: assert property (
        wrHit(regAddr, regWrite, ENABLE_DIM_ADDR)
        |=> backlightFeedbackReference == $past(regWrData[DIM_MSB:0]))
        else $error("Dimming reference did not follow write.");
    // The switching mode bits follow a write of the mode register.
    a_mode_write: assert property (
        wrHit(regAddr, regWrite, MODE_LDO_ADDR) |=>
        switchingModeSelect == $past(regWrData[7:4]))
        else $error("Mode bits did not follow write.");
    // The LDO level code follows a write of the mode register.
    a_ldo_write: assert property (
        wrHit(regAddr, regWrite, MODE_LDO_ADDR) |=>
        ldoOutputCode == $past(regWrData[3:0]))
        else $error("LDO code did not follow write.");
    // The three channel enables follow a write of the enable register.
    a_enable_write: assert property (
        wrHit(regAddr, regWrite, ENABLE_DIM_ADDR)
        |=> {buckCEnable, lowInputLdoEnable, secondLdoEnable}
            == $past(regWrData[BUCK_C_EN_BIT:SECOND_LDO_EN_BIT]))
        else $error("Enables did not follow write.");
    // The enables never move on their own.
    a_enable_hold: assert property (
        !wrHit(regAddr, regWrite, ENABLE_DIM_ADDR)
        |=> $stable({buckCEnable, lowInputLdoEnable, secondLdoEnable}))
        else $error("Enable changed without a write.");
    // A mode register read returns the live mode and level fields.
    a_read_mode: assert property (
        regRead && regAddr == MODE_LDO_ADDR && !regWrite |=>
        regRdData == {switchingModeSelect, ldoOutputCode})
        else $error("Mode register read wrong.");

    // Main scenarios.
    c_fault_seen: cover property (@(posedge clk) disable iff (!rstn)
        faultFlags_reg == 8'hff);
    c_backlight_on: cover property (@(posedge clk) disable iff (!rstn)
        backlightEnable && backlightFeedbackReference == DIM_FULL);
    c_force_pwm: cover property (@(posedge clk) disable iff (!rstn)
        switchingModeSelect == 4'h0);
    c_fault_clear: cover property (@(posedge clk) disable iff (!rstn)
        $fell(faultFlags_reg[7]));
endmodule : pmu_channel_control_regs

//--- verif/host_model.sv
// Host model that drives the byte-wide register port.
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWrData,
    output logic            regRead
);
    // The port is idle before the first access.
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWrData = 8'h00;
        regRead = 1'b0;
    end
    // One write strobe, held up to exactly one taking edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    // Read data is taken after the answering edge has settled.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
endmodule : host_model

//--- verif/tb_pmu_channel_control_regs.sv
// Self-checking bench for the channel control registers.
`timescale 1ns/1ps
module tb_pmu_channel_control_regs;
    import pmu_regs_pkg::*;
    logic clk, rstn, regWrite, regRead, buckCEnable, lowInputLdoEnable;
    logic secondLdoEnable, backlightEnable;
    logic [7:0] regAddr, regWrData, regRdData, faultEvent, rd, e, m, acc;
    logic [4:0] backlightFeedbackReference;
    logic [3:0] switchingModeSelect, ldoOutputCode;
    logic [31:0] seed = 32'h6495968e;  // Fixed seed keeps runs repeatable.
    logic [7:0] rstv [1:3] = '{FAULT_FLAGS_RESET, ENABLE_DIM_RESET,
                               MODE_LDO_RESET};
    int n_fail = 0, samples_checked = 0, cyc = 0;
    pmu_channel_control_regs u_dut (.clk(clk), .rstn(rstn),
        .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
        .regRead(regRead), .regRdData(regRdData), .faultEvent(faultEvent),
        .buckCEnable(buckCEnable), .lowInputLdoEnable(lowInputLdoEnable),
        .secondLdoEnable(secondLdoEnable), .backlightEnable(backlightEnable),
        .backlightFeedbackReference(backlightFeedbackReference),
        .switchingModeSelect(switchingModeSelect),
        .ldoOutputCode(ldoOutputCode));
    host_model u_host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead));
    // Xorshift step for the random stimulus.
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    // Expected enable outputs: three enables, backlight on, reference.
    function automatic logic [15:0] ctlOf(input logic [7:0] d);
        return {7'h00, d[7:5], |d[4:0], d[4:0]};
    endfunction : ctlOf
    // Control outputs packed in the same order as ctlOf builds them.
    function automatic logic [15:0] ctlNow();
        return {7'h00, buckCEnable, lowInputLdoEnable, secondLdoEnable,
                backlightEnable, backlightFeedbackReference};
    endfunction : ctlNow
    // Mode and level outputs packed as the mode register holds them.
    function automatic logic [7:0] modeNow();
        return {switchingModeSelect, ldoOutputCode};
    endfunction : modeNow
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // A hang is cut short well past the roughly 140 cycles needed.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        rstn = 1'b0;
        faultEvent = 8'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(ctlNow(), 16'h0000);
        chk(modeNow(), MODE_LDO_RESET);
        for (int i = 1; i < 4; i++) begin
            u_host.rd(8'(i), rd);
            chk(rd, rstv[i]);
        end
        $display("test reset values done");
        // Corners first: all set, all clear, smallest dimming code.
        for (int i = 0; i < 12; i++) begin
            seed = nxt(seed);
            case (i)
                0: e = 8'hff;
                1: e = 8'h00;
                2: e = 8'h01;
                default: e = seed[7:0];
            endcase
            u_host.wr(ENABLE_DIM_ADDR, e);
            u_host.wr(MODE_LDO_ADDR, e);
            chk(ctlNow(), ctlOf(e));
            chk(modeNow(), e);
            u_host.rd(ENABLE_DIM_ADDR, rd);
            chk(rd, e);
        end
        $display("test enables and modes done");
        acc = 8'h00;
        // Flags gather across events; the first pulse hits the top channel.
        for (int i = 0; i < 4; i++) begin
            seed = nxt(seed);
            m = (i == 0) ? 8'h80 : seed[7:0];
            acc = acc | m;
            @(posedge clk) faultEvent <= m;
            @(posedge clk) faultEvent <= 8'h00;
            repeat (4) @(posedge clk);
            u_host.rd(FAULT_FLAGS_ADDR, rd);
            chk(rd, acc);
        end
        u_host.wr(FAULT_FLAGS_ADDR, 8'h00);
        u_host.rd(FAULT_FLAGS_ADDR, rd);
        chk(rd, 8'h00);
        u_host.wr(FAULT_FLAGS_ADDR, 8'h5a);
        u_host.rd(FAULT_FLAGS_ADDR, rd);
        chk(rd, 8'h5a);
        $display("test fault flags done");
        // Unmapped offsets neither read back nor disturb the controls.
        for (int a = 0; a < 256; a += 128) begin
            u_host.wr(8'(a), 8'ha5);
            u_host.rd(8'(a), rd);
            chk(rd, UNMAPPED_READ);
        end
        chk(modeNow(), e);
        chk(ctlNow(), ctlOf(e));
        $display("test unmapped done");
        // A reset in mid-run brings every control back to its reset value.
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(ctlNow(), 16'h0000);
        chk(modeNow(), MODE_LDO_RESET);
        u_host.rd(FAULT_FLAGS_ADDR, rd);
        chk(rd, FAULT_FLAGS_RESET);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : tb_pmu_channel_control_regs
